/* serial_flash_register_commands.sv */
`timescale 1ns/1ps
module serial_flash_register_commands #(
  parameter int WRITE_CYCLES = flash_reg_pkg::REGISTER_WRITE_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // serial link
  input wire logic cs_b_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // protection pin and array fault
  input wire logic write_protect_b_i,
  input wire logic write_fail_i,
  // register view
  output logic [7:0] status_one_o,
  output logic [7:0] status_two_o,
  output logic [7:0] config_o,
  output logic [7:0] bank_address_register_o,
  output logic [7:0] high_address_o,
  output logic busy_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic sck_prev;
    logic cs_prev;
    logic [5:0] bit_cnt;
    logic [7:0] opcode;
    logic [23:0] data;
    logic [7:0] out_sh;
    logic so;
    logic so_oe;
    logic [7:0] sr1;
    logic [7:0] cr;
    logic [7:0] sr2;
    logic [7:0] bar;
    logic [7:0] high_addr;
    logic bank_open;
    logic [31:0] timer;
  } state_t;

  state_t st;
  state_t next_st;

  logic [4:0] pins;
  logic cs_b;
  logic sck;
  logic si;
  logic wp_b;
  logic fail;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  pin_sync #(
    .WIDTH(flash_reg_pkg::PIN_COUNT),
    .IDLE(flash_reg_pkg::PIN_IDLE)
  ) u_pin_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .pins_i({write_fail_i, si_i, sck_i, write_protect_b_i, cs_b_i}),
    .pins_o(pins)
  );

  assign cs_b = pins[0];
  assign wp_b = pins[1];
  assign sck = pins[2];
  assign si = pins[3];
  assign fail = pins[4];

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // keeps read-only bits, lets one-time bits only rise
  function automatic logic [7:0] merge_write(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic [7:0] wmask, input logic [7:0] otp);
    merge_write = (old_v & ~wmask) | (new_v & wmask & ~otp) | ((old_v | new_v) & otp & wmask);
  endfunction

  function automatic logic [7:0] read_value(input logic [7:0] op, input state_t s);
    case (op)
      flash_reg_pkg::OP_READ_STATUS_ONE: read_value = s.sr1;
      flash_reg_pkg::OP_READ_STATUS_TWO: read_value = s.sr2;
      flash_reg_pkg::OP_READ_CONFIG: read_value = s.cr;
      flash_reg_pkg::OP_BANK_READ: read_value = s.bar;
      default: read_value = 8'h00;
    endcase
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == flash_reg_pkg::OP_READ_STATUS_ONE) ||
              (op == flash_reg_pkg::OP_READ_STATUS_TWO) ||
              (op == flash_reg_pkg::OP_READ_CONFIG) ||
              (op == flash_reg_pkg::OP_BANK_READ);
  endfunction

  // first data byte sits deeper in the shifter the more bytes follow it
  function automatic logic [7:0] data_byte(input logic [23:0] d, input logic [5:0] cnt,
                                           input logic [1:0] idx);
    logic [1:0] total;
    total = 2'h0;
    case (cnt)
      flash_reg_pkg::ONE_BYTE_BITS: total = 2'h1;
      flash_reg_pkg::TWO_BYTE_BITS: total = 2'h2;
      default: total = 2'h3;
    endcase
    case (total - idx)
      2'h0: data_byte = d[7:0];
      2'h1: data_byte = d[15:8];
      2'h2: data_byte = d[23:16];
      default: data_byte = 8'h00;
    endcase
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic [7:0] op_now;
    logic frame_ok;
    logic permitted;
    logic [7:0] b1;
    logic [7:0] new_sr1;
    logic [7:0] new_cr;
    logic [7:0] new_sr2;
    logic nv_change;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    op_now = 8'h00;
    frame_ok = 1'b0;
    permitted = 1'b0;
    b1 = 8'h00;
    new_sr1 = 8'h00;
    new_cr = 8'h00;
    new_sr2 = 8'h00;
    nv_change = 1'b0;
    next_st = st;
    next_st.sck_prev = sck;
    next_st.cs_prev = cs_b;
    sck_rise = !cs_b && sck && !st.sck_prev;
    sck_fall = !cs_b && !sck && st.sck_prev;
    cs_fall = !cs_b && st.cs_prev;
    cs_rise = cs_b && !st.cs_prev;
    op_now = {st.opcode[6:0], si};

    // ----------------------------------------
    // self-timed write completion
    // ----------------------------------------
    if (st.sr1[flash_reg_pkg::SR1_BUSY_BIT]) begin
      if (st.timer <= 32'h0000_0001) begin
        next_st.timer = 32'h0000_0000;
        next_st.sr1[flash_reg_pkg::SR1_BUSY_BIT] = 1'b0;
        next_st.sr1[flash_reg_pkg::SR1_WEL_BIT] = 1'b0;
        if (fail) begin
          next_st.sr1[flash_reg_pkg::SR1_PROGRAM_ERR_BIT] = 1'b1;
        end
      end else begin
        next_st.timer = st.timer - 32'h0000_0001;
      end
    end

    // ----------------------------------------
    // frame start and bit shifting
    // ----------------------------------------
    if (cs_fall) begin
      next_st.bit_cnt = 6'h00;
      next_st.opcode = 8'h00;
      next_st.data = 24'h00_0000;
    end else if (sck_rise) begin
      // long reads wrap to a byte boundary so the stream never sticks
      next_st.bit_cnt = (st.bit_cnt != flash_reg_pkg::BIT_COUNT_MAX) ? st.bit_cnt + 6'h01 :
                        is_read(st.opcode) ? flash_reg_pkg::CMD_BITS : st.bit_cnt;
      if (st.bit_cnt < flash_reg_pkg::CMD_BITS) begin
        next_st.opcode = op_now;
      end else begin
        next_st.data = {st.data[22:0], si};
      end
      // fresh value loaded at every byte boundary of a read
      if (st.bit_cnt == flash_reg_pkg::CMD_BITS - 6'h01 && is_read(op_now)) begin
        next_st.out_sh = read_value(op_now, st);
      end else if (st.bit_cnt >= flash_reg_pkg::CMD_BITS && st.bit_cnt[2:0] == 3'h7 &&
                   is_read(st.opcode)) begin
        next_st.out_sh = read_value(st.opcode, st);
      end
    end else if (sck_fall && st.bit_cnt >= flash_reg_pkg::CMD_BITS && is_read(st.opcode)) begin
      next_st.so = st.out_sh[7];
      next_st.so_oe = 1'b1;
      next_st.out_sh = {st.out_sh[6:0], 1'b0};
    end

    // ----------------------------------------
    // command execution on select rise
    // ----------------------------------------
    if (cs_rise) begin
      next_st.so_oe = 1'b0;
      next_st.so = 1'b0;
      next_st.bank_open = 1'b0;
      b1 = data_byte(st.data, st.bit_cnt, 2'h1);
      case (st.opcode)
        flash_reg_pkg::OP_WRITE_ENABLE: begin
          if (st.bit_cnt == flash_reg_pkg::CMD_BITS) begin
            next_st.sr1[flash_reg_pkg::SR1_WEL_BIT] = 1'b1;
          end
        end
        flash_reg_pkg::OP_BANK_ACCESS_PREFIX: begin
          if (st.bit_cnt == flash_reg_pkg::CMD_BITS) begin
            next_st.bank_open = 1'b1;
          end
        end
        flash_reg_pkg::OP_BANK_WRITE: begin
          // status flags untouched: only the bank register moves
          if (st.bit_cnt == flash_reg_pkg::ONE_BYTE_BITS) begin
            next_st.bar = st.data[7:0] & flash_reg_pkg::BAR_WRITE_MASK;
          end
        end
        flash_reg_pkg::OP_WRITE_REGISTERS: begin
          if (st.bank_open) begin
            // prefixed form: no latch needed, second byte dropped, no busy
            if (st.bit_cnt >= flash_reg_pkg::ONE_BYTE_BITS) begin
              next_st.bar = (st.bar & ~flash_reg_pkg::BAR_PREFIX_MASK) |
                            (b1 & flash_reg_pkg::BAR_PREFIX_MASK);
            end
          end else begin
            frame_ok = (st.bit_cnt == flash_reg_pkg::ONE_BYTE_BITS) ||
                       (st.bit_cnt == flash_reg_pkg::TWO_BYTE_BITS) ||
                       (st.bit_cnt == flash_reg_pkg::THREE_BYTE_BITS);
            permitted = st.sr1[flash_reg_pkg::SR1_WEL_BIT] &&
                        !(st.sr1[flash_reg_pkg::SR1_WRITE_DISABLE_BIT] && !wp_b &&
                          !st.cr[flash_reg_pkg::CR_QUAD_BIT]);
            new_sr1 = merge_write(st.sr1, b1, flash_reg_pkg::SR1_WRITE_MASK, 8'h00);
            new_cr = st.cr;
            new_sr2 = st.sr2;
            if (st.bit_cnt >= flash_reg_pkg::TWO_BYTE_BITS) begin
              new_cr = merge_write(st.cr, data_byte(st.data, st.bit_cnt, 2'h2),
                                   flash_reg_pkg::CR_WRITE_MASK,
                                   flash_reg_pkg::CR_OTP_MASK);
            end
            if (st.bit_cnt == flash_reg_pkg::THREE_BYTE_BITS) begin
              new_sr2 = merge_write(st.sr2, data_byte(st.data, st.bit_cnt, 2'h3),
                                    flash_reg_pkg::SR2_WRITE_MASK, 8'h00);
            end
            nv_change = |((new_sr1 ^ st.sr1) & flash_reg_pkg::SR1_NV_MASK) ||
                        |((new_cr ^ st.cr) & flash_reg_pkg::CR_NV_MASK) ||
                        |((new_sr2 ^ st.sr2) & flash_reg_pkg::SR2_NV_MASK);
            // a write in flight owns the registers until it ends
            if (frame_ok && permitted && !st.sr1[flash_reg_pkg::SR1_BUSY_BIT]) begin
              next_st.sr1 = new_sr1;
              next_st.sr1[flash_reg_pkg::SR1_BUSY_BIT] = 1'b1;
              next_st.cr = new_cr;
              next_st.sr2 = new_sr2;
              next_st.timer = nv_change ? 32'(WRITE_CYCLES) :
                              32'(flash_reg_pkg::SELECT_HIGH_CYCLES);
            end
          end
        end
        default: begin
          next_st.bank_open = 1'b0;
        end
      endcase
    end

    // high address bits come from the bank only in three-byte mode
    next_st.high_addr = next_st.bar[flash_reg_pkg::BAR_EXT_BIT] ? 8'h00 :
                        (next_st.bar & ~(8'h01 << flash_reg_pkg::BAR_EXT_BIT));
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      st.sck_prev <= 1'b0;
      st.cs_prev <= 1'b1;
      st.bit_cnt <= 6'h00;
      st.opcode <= 8'h00;
      st.data <= 24'h00_0000;
      st.out_sh <= 8'h00;
      st.so <= 1'b0;
      st.so_oe <= 1'b0;
      st.sr1 <= flash_reg_pkg::SR1_RESET;
      st.cr <= flash_reg_pkg::CR_RESET;
      st.sr2 <= flash_reg_pkg::SR2_RESET;
      st.bar <= flash_reg_pkg::BAR_RESET;
      st.high_addr <= flash_reg_pkg::BAR_RESET;
      st.bank_open <= 1'b0;
      st.timer <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign so_o = st.so;
  assign so_oe_o = st.so_oe;
  assign status_one_o = st.sr1;
  assign status_two_o = st.sr2;
  assign config_o = st.cr;
  assign bank_address_register_o = st.bar;
  assign high_address_o = st.high_addr;
  assign busy_o = st.sr1[flash_reg_pkg::SR1_BUSY_BIT];

endmodule

/* flash_reg_pkg.sv */
package flash_reg_pkg;

  // ----------------------------------------
  // clock
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;

  // ----------------------------------------
  // command opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_READ_STATUS_ONE = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_TWO = 8'h07;
  localparam logic [7:0] OP_READ_CONFIG = 8'h35;
  localparam logic [7:0] OP_BANK_READ = 8'h16;
  localparam logic [7:0] OP_BANK_WRITE = 8'h17;
  localparam logic [7:0] OP_BANK_ACCESS_PREFIX = 8'hB9;
  localparam logic [7:0] OP_WRITE_REGISTERS = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SR1_WRITE_DISABLE_BIT = 7;
  localparam int SR1_PROGRAM_ERR_BIT = 6;
  localparam int SR1_ERASE_ERR_BIT = 5;
  localparam int SR1_WEL_BIT = 1;
  localparam int SR1_BUSY_BIT = 0;
  localparam int CR_QUAD_BIT = 1;
  localparam int BAR_EXT_BIT = 7;

  // ----------------------------------------
  // write masks: writable, one-time, non-volatile
  // ----------------------------------------
  localparam logic [7:0] SR1_WRITE_MASK = 8'h9C;
  localparam logic [7:0] SR1_NV_MASK = 8'h9C;
  localparam logic [7:0] CR_WRITE_MASK = 8'hFE;
  localparam logic [7:0] CR_OTP_MASK = 8'h3C;
  localparam logic [7:0] CR_NV_MASK = 8'h3E;
  localparam logic [7:0] SR2_WRITE_MASK = 8'hFF;
  localparam logic [7:0] SR2_NV_MASK = 8'h00;
  localparam logic [7:0] BAR_WRITE_MASK = 8'h83;
  localparam logic [7:0] BAR_PREFIX_MASK = 8'h03;

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] CR_RESET = 8'h00;
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam logic [7:0] BAR_RESET = 8'h00;

  // ----------------------------------------
  // frame bit counts (opcode plus data)
  // ----------------------------------------
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ONE_BYTE_BITS = 6'h10;
  localparam logic [5:0] TWO_BYTE_BITS = 6'h18;
  localparam logic [5:0] THREE_BYTE_BITS = 6'h20;
  localparam logic [5:0] BIT_COUNT_MAX = 6'h3F;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SELECT_HIGH_TIME_NS = 50;
  localparam int REGISTER_WRITE_TIME_NS = 200000000;
  localparam int SELECT_HIGH_CYCLES_RAW = SELECT_HIGH_TIME_NS / CLK_PERIOD_NS;
  localparam int SELECT_HIGH_CYCLES = (SELECT_HIGH_CYCLES_RAW < 1) ? 1 : SELECT_HIGH_CYCLES_RAW;
  localparam int REGISTER_WRITE_CYCLES = REGISTER_WRITE_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  localparam int PIN_COUNT = 5;
  localparam logic [4:0] PIN_IDLE = 5'h03;

endpackage

/* pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // pins
  input wire logic [WIDTH-1:0] pins_i,
  output logic [WIDTH-1:0] pins_o
);

  // ----------------------------------------
  // two stages; first stage feeds only the second
  // ----------------------------------------
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      stage_one <= IDLE;
      pins_o <= IDLE;
    end else begin
      stage_one <= pins_i;
      pins_o <= stage_one;
    end
  end

endmodule

/* serial_flash_register_commands_properties.sv */
`timescale 1ns/1ps
module serial_flash_register_commands_properties #(
  parameter int WRITE_CYCLES = 20
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // serial link
  input wire logic cs_b_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  // pins
  input wire logic write_protect_b_i,
  input wire logic write_fail_i,
  // register view
  input wire logic [7:0] status_one_o,
  input wire logic [7:0] status_two_o,
  input wire logic [7:0] config_o,
  input wire logic [7:0] bank_address_register_o,
  input wire logic [7:0] high_address_o,
  input wire logic busy_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // ------
  // busy length
  // ------
  // saturates so a stuck busy still trips the bound
  logic [31:0] busy_len;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || !busy_o) begin
      busy_len <= 32'h0;
    end else if (busy_len != 32'hFFFFFFFF) begin
      busy_len <= busy_len + 32'h1;
    end
  end
  // ------
  // checks
  // ------
  chk_busy_mirror: assert property (busy_o == status_one_o[0])
    else $error("busy port differs from status bit");
  chk_busy_bound: assert property (busy_len <= WRITE_CYCLES + 4)
    else $error("register write busy too long");
  chk_busy_needs_wel: assert property ($rose(busy_o) |-> status_one_o[1])
    else $error("timed write started without latch");
  chk_wel_clear: assert property ($fell(busy_o) |-> !status_one_o[1])
    else $error("latch still set after write");
  chk_err_at_end: assert property ($rose(status_one_o[6]) |-> $fell(busy_o))
    else $error("error flag set outside write completion");
  chk_oe_release: assert property (cs_b_i [*6] |-> !so_oe_o)
    else $error("output driven while deselected");
  chk_bank_flags: assert property ($changed(bank_address_register_o) |->
    $stable(status_one_o[6:5]) && $stable(busy_o))
    else $error("bank write disturbed status flags");
  chk_high_bank: assert property (!bank_address_register_o[7] &&
    $stable(bank_address_register_o) |-> high_address_o == {1'b0, bank_address_register_o[6:0]})
    else $error("high address not from bank");
  chk_high_ext: assert property (bank_address_register_o[7] &&
    $stable(bank_address_register_o) |-> high_address_o == 8'h00)
    else $error("high address used in extended mode");
  chk_otp_sticky: assert property
    ((($past(config_o) & ~config_o) & flash_reg_pkg::CR_OTP_MASK) == 8'h00)
    else $error("one-time bit cleared");
  chk_protect_freeze: assert property ((!write_protect_b_i) [*4] ##0
    (status_one_o[7] && !config_o[1]) |=> $stable(status_one_o[7:2]))
    else $error("protected bits changed");
endmodule
bind serial_flash_register_commands serial_flash_register_commands_properties #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_props (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .sck_i(sck_i), .si_i(si_i),
  .so_o(so_o), .so_oe_o(so_oe_o), .write_protect_b_i(write_protect_b_i),
  .write_fail_i(write_fail_i), .status_one_o(status_one_o), .status_two_o(status_two_o),
  .config_o(config_o), .bank_address_register_o(bank_address_register_o),
  .high_address_o(high_address_o), .busy_o(busy_o)
);

/* spi_host.sv */
`timescale 1ns/1ps
module spi_host (
  // clock
  input wire logic clock_i,
  // serial link
  output logic cs_b_o,
  output logic sck_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    cs_b_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic wait_neg(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // ------
  // one frame, msb first, last 16 bits kept
  // ------
  // mode 0: sck idles low and stands still between frames
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0;
    wait_neg(1);
    cs_b_o = 1'b0;
    wait_neg(4);
    for (int i = nbits - 1; i >= 0; i--) begin
      si_o = tx[i];
      wait_neg(4);
      sck_o = 1'b1;
      wait_neg(4);
      rx = {rx[14:0], so_i};
      sck_o = 1'b0;
    end
    wait_neg(4);
    cs_b_o = 1'b1;
    // released line shows no stale bit
    si_o = ~si_o;
    wait_neg(8);
  endtask
endmodule

/* serial_flash_register_commands_tb.sv */
`timescale 1ns/1ps
module serial_flash_register_commands_tb;
  localparam int WRITE_CYCLES = 100;
  logic clock_i;
  logic rst_b_i;
  logic cs_b, sck, si, so, so_oe, write_protect_b, write_fail, busy;
  logic [7:0] status_one, status_two, config_reg, bank_reg, high_address;
  logic [15:0] rx;
  logic [7:0] ops [3] = '{8'h07, 8'h35, 8'h16};
  logic [7:0] exps [3] = '{8'hA5, 8'h04, 8'h82};
  int errors;
  int samples_checked;
  serial_flash_register_commands #(.WRITE_CYCLES(WRITE_CYCLES)) u_dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sck_i(sck), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .write_protect_b_i(write_protect_b), .write_fail_i(write_fail),
    .status_one_o(status_one), .status_two_o(status_two), .config_o(config_reg),
    .bank_address_register_o(bank_reg), .high_address_o(high_address), .busy_o(busy)
  );
  spi_host u_host (
    .clock_i(clock_i), .cs_b_o(cs_b), .sck_o(sck), .si_o(si), .so_i(so)
  );
  // ------
  // helpers
  // ------
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, expected);
    end
  endtask
  task automatic cmd(input logic [31:0] tx, input int nbits);
    u_host.xfer(tx, nbits, rx);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400 && busy === 1'b1; i++) @(negedge clock_i);
  endtask
  task automatic close_out();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // generous: the whole sequence needs under 10000 cycles
  initial begin
    repeat (30000) @(posedge clock_i);
    errors++;
    close_out();
  end
  // ------
  // sequence
  // ------
  initial begin
    rst_b_i = 1'b0;
    write_protect_b = 1'b1;
    write_fail = 1'b0;
    errors = 0;
    samples_checked = 0;
    repeat (3) @(negedge clock_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clock_i);
    cmd(32'h1783, 16);
    check(bank_reg, 8'h83);
    check(high_address, 8'h00);
    cmd(32'h1702, 16);
    check(high_address, 8'h02);
    // prefix then write-registers touches bank bits only
    cmd(32'h1780, 16);
    cmd(32'hB9, 8);
    cmd(32'h01FE, 16);
    check(bank_reg, 8'h82);
    check(status_one, 8'h00);
    cmd(32'hB9, 8);
    cmd(32'h0500, 16);
    cmd(32'h0103, 16);
    check(bank_reg, 8'h82);
    // latch gating and exact-length enable
    cmd(32'h011C, 16);
    check(status_one, 8'h00);
    cmd(32'h0C, 9);
    check(status_one, 8'h00);
    cmd(32'h06, 8);
    check(status_one, 8'h02);
    cmd(32'h011C4, 20);
    check(status_one, 8'h02);
    // pin low but write disable clear, so write goes ahead
    write_protect_b = 1'b0;
    cmd(32'h011C04A5, 32);
    cmd(32'h050000, 24);
    check(rx[15:8], 8'h1F);
    check(rx[7:0], 8'h1C);
    check({7'h00, so_oe}, 8'h00);
    for (int k = 0; k < 3; k++) begin
      cmd({8'h00, ops[k], 16'h0000}, 24);
      check(rx[15:8], exps[k]);
      check(rx[7:0], exps[k]);
    end
    wait_idle();
    cmd(32'h06, 8);
    cmd(32'h019C01, 24);
    wait_idle();
    check(status_one, 8'h9C);
    check(config_reg, 8'h04);
    cmd(32'h06, 8);
    cmd(32'h0100, 16);
    wait_idle();
    check(status_one & 8'hFC, 8'h9C);
    write_protect_b = 1'b1;
    cmd(32'h06, 8);
    cmd(32'h0100, 16);
    wait_idle();
    check(status_one, 8'h00);
    // only volatile bits change: short busy
    cmd(32'h06, 8);
    cmd(32'h0100045A, 32);
    check({7'h00, busy}, 8'h00);
    check(status_two, 8'h5A);
    // quad mode: protect pin turns into data, so pin protection is off
    cmd(32'h06, 8);
    cmd(32'h018006, 24);
    wait_idle();
    check(config_reg, 8'h06);
    write_protect_b = 1'b0;
    cmd(32'h06, 8);
    cmd(32'h018406, 24);
    wait_idle();
    check(status_one, 8'h84);
    // errors never clear here, so this goes last
    write_fail = 1'b1;
    cmd(32'h06, 8);
    cmd(32'h010406, 24);
    wait_idle();
    check(status_one, 8'h44);
    close_out();
  end
endmodule
